// ---- core/mdn_pkg.sv ----
// Shared constants, types and decode helpers of the multiply and decimal negate unit
package mdn_pkg;
    // ==================================================================
    // Instruction patterns
    localparam logic [9:0] LONG_MUL_PAT = 10'h130; // 0100110000, long-form multiply
    localparam logic [9:0] DNEG_PAT = 10'h120; // 0100100000, decimal negate
    localparam logic [3:0] WORD_MUL_PAT = 4'hc; // 1100 in bits 15:12
    localparam logic [2:0] WORD_UNS_SUB = 3'h3; // 011 in bits 8:6
    localparam int OPW_TOP_LSB = 6; // Low end of the 10-bit pattern
    localparam int OPW_NIB_LSB = 12; // Low end of the 4-bit pattern
    localparam int OPW_SUB_LSB = 6; // Low end of the 3-bit sub-pattern
    localparam int OPW_DREG_LSB = 9; // Word-form destination register
    localparam int EA_MODE_LSB = 3; // Effective address mode field
    localparam int EA_REG_LSB = 0; // Effective address register field
    // ==================================================================
    // Extension word of the long form
    localparam int EXT_ZERO_BIT = 15; // Must be zero
    localparam int EXT_LO_LSB = 12; // Low result register
    localparam int EXT_SIGN_BIT = 11; // 1 signed, 0 unsigned
    localparam int EXT_SIZE_BIT = 10; // 1 selects a 64-bit product
    localparam int EXT_RSV_LSB = 3; // Bits 9:3 must be zero
    localparam int EXT_RSV_W = 7;
    localparam int EXT_HI_LSB = 0; // High result register
    // ==================================================================
    // Effective address encodings
    localparam logic [2:0] MODE_DREG = 3'h0; // Data register direct
    localparam logic [2:0] MODE_AREG = 3'h1; // Address register direct
    localparam logic [2:0] MODE_EXT = 3'h7; // Absolute, PC-relative, immediate
    localparam logic [2:0] XREG_ABS_L = 3'h1; // Highest absolute encoding
    localparam logic [2:0] XREG_IMM = 3'h4; // Immediate data
    // ==================================================================
    // Condition code bit positions
    localparam int CCR_W = 5;
    localparam int CC_X = 4;
    localparam int CC_N = 3;
    localparam int CC_Z = 2;
    localparam int CC_V = 1;
    localparam int CC_C = 0;
    // ==================================================================
    // Register port map and fields
    localparam logic [3:0] ADDR_CTRL = 4'h0; // Control: unit enable
    localparam logic [3:0] ADDR_STAT = 4'h4; // Status: refusal, last op, overflow
    localparam logic [3:0] ADDR_COUNT = 4'h8; // Completed operation count
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1; // Unit runs after reset
    localparam int STAT_REF_BIT = 0; // Sticky refusal, write one to clear
    localparam int STAT_V_BIT = 1; // Overflow of the last accepted operation, zero after a negate
    localparam int STAT_OP_LSB = 4; // Kind of the last accepted operation
    localparam int COUNT_W = 16;
    // ==================================================================
    // Operation kinds
    typedef enum logic [1:0] {OP_NONE, OP_MUL_LONG, OP_MUL_WORD, OP_DNEG} mdn_op_t;

    // Data addressing modes: everything but address register direct
    function automatic logic ea_is_data(input logic [2:0] mode, input logic [2:0] rg);
        ea_is_data = (mode == MODE_AREG) ? 1'b0 : ((mode != MODE_EXT) || (rg <= XREG_IMM));
    endfunction

    // Data alterable: no address register, no PC-relative, no immediate
    function automatic logic ea_is_data_alt(input logic [2:0] mode, input logic [2:0] rg);
        ea_is_data_alt = (mode == MODE_AREG) ? 1'b0 : ((mode != MODE_EXT) || (rg <= XREG_ABS_L));
    endfunction
endpackage

// ---- core/mdn_dp_if.sv ----
// Connection between the unit's control and its two arithmetic engines
`timescale 1ns/1ps
interface mdn_dp_if;
    logic [31:0] mul_a; // Multiplicand
    logic [31:0] mul_b; // Multiplier
    logic mul_signed; // Two's complement operands
    logic [63:0] mul_prod; // Full quad product
    logic [7:0] bcd_in; // Packed decimal operand
    logic bcd_x; // Extend flag entering
    logic [7:0] bcd_out; // Packed decimal result
    logic bcd_borrow; // Decimal borrow out

    modport mul_mp (input mul_a, input mul_b, input mul_signed, output mul_prod);
    modport bcd_mp (input bcd_in, input bcd_x, output bcd_out, output bcd_borrow);
    modport core_mp (output mul_a, output mul_b, output mul_signed, input mul_prod,
                     output bcd_in, output bcd_x, input bcd_out, input bcd_borrow);
endinterface // mdn_dp_if

// ---- core/mdn_mul.sv ----
// Single-cycle 32x32 multiplier, signed or unsigned, full 64-bit product
`timescale 1ns/1ps
module mdn_mul (
    mdn_dp_if.mul_mp dp
);
    // ==================================================================
    // Operand extension
    // Extending to 64 bits first keeps the whole quad product in range
    logic [63:0] a_ext;
    logic [63:0] b_ext;
    assign a_ext = {{32{dp.mul_signed & dp.mul_a[31]}}, dp.mul_a};
    assign b_ext = {{32{dp.mul_signed & dp.mul_b[31]}}, dp.mul_b};

    // Low 64 bits of the extended product are exact in both modes
    assign dp.mul_prod = a_ext * b_ext;
endmodule // mdn_mul

// ---- core/mdn_bcd.sv ----
// Packed decimal negate of one byte: zero minus operand minus extend
`timescale 1ns/1ps
module mdn_bcd (
    mdn_dp_if.bcd_mp dp
);
    // ==================================================================
    // Digit step
    // Zero minus digit minus borrow; returns {borrow, digit}
    function automatic logic [4:0] neg_digit(input logic [3:0] d, input logic b);
        logic [4:0] sub;
        sub = {1'b0, d} + {4'h0, b};
        if (sub == 5'h00) begin
            neg_digit = 5'h00; // Nothing to take: no borrow
        end else begin
            neg_digit = {1'b1, 4'(5'h0a - sub)}; // Borrow ten from next digit
        end
    endfunction

    logic [4:0] lo_step;
    logic [4:0] hi_step;
    // Low digit takes the extend flag, high digit the low digit's borrow
    assign lo_step = neg_digit(dp.bcd_in[3:0], dp.bcd_x);
    assign hi_step = neg_digit(dp.bcd_in[7:4], lo_step[4]);
    assign dp.bcd_out = {hi_step[3:0], lo_step[3:0]};
    assign dp.bcd_borrow = hi_step[4];
endmodule // mdn_bcd

// ---- core/mdn_unit.sv ----
// Top of the multiply and decimal negate unit with its register port
// How it works
// RL1 - Multiply source must be data mode
// RL2 - Low register gives multiplicand, takes low product
// RL3 - Width bit picks 32 or 64-bit product
// RL4 - Width set: high half to high register
// RL5 - Same high and low register is undefined
// RL6 - Unsigned multiply; word form 16x16 to 32
// RL7 - Word form uses low halves, stores 32
// RL8 - Long 32-bit result keeps low half only
// RL9 - Multiply: X kept, C cleared, N Z set
// RL10 - Unsigned V: discarded high half nonzero
// RL11 - Signed V: high half not sign extension
// RL12 - Decimal negate byte: zero minus operand minus X
// RL13 - X clear tens complement, set nines
// RL14 - Decimal negate: C on borrow, X copies C
// RL15 - Decimal negate clears Z only if nonzero
// RL16 - Software presets Z before multi-byte negate
// RL17 - Long form pattern; extension bit 11 signed
// RL18 - Word unsigned and decimal negate patterns
`timescale 1ns/1ps
module mdn_unit (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic op_valid_i,
    input wire logic [15:0] opword_i,
    input wire logic [15:0] extword_i,
    input wire logic [31:0] src_i,
    input wire logic [31:0] dst_i,
    input wire logic [mdn_pkg::CCR_W-1:0] ccr_i,
    output logic done_o,
    output logic refused_o,
    output logic lo_wr_o,
    output logic [2:0] lo_idx_o,
    output logic [31:0] lo_data_o,
    output logic hi_wr_o,
    output logic [2:0] hi_idx_o,
    output logic [31:0] hi_data_o,
    output logic mem_wr_o,
    output logic [mdn_pkg::CCR_W-1:0] ccr_o,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o
);
    import mdn_pkg::*;

    // ==================================================================
    // Instruction fields
    logic [2:0] ea_mode; // Source or destination mode
    logic [2:0] ea_reg; // Register half of the address field
    logic [2:0] lo_num; // Long-form low result register
    logic [2:0] hi_num; // Long-form high result register
    logic [2:0] word_idx; // Word-form destination register
    logic ext_signed; // Long form operates signed
    logic ext_wide; // Long form returns 64 bits
    logic ext_ok; // Fixed extension bits are zero

    assign ea_mode = opword_i[EA_MODE_LSB +: 3];
    assign ea_reg = opword_i[EA_REG_LSB +: 3];
    assign lo_num = extword_i[EXT_LO_LSB +: 3];
    assign hi_num = extword_i[EXT_HI_LSB +: 3];
    assign word_idx = opword_i[OPW_DREG_LSB +: 3];
    assign ext_signed = extword_i[EXT_SIGN_BIT]; // see RL17
    assign ext_wide = extword_i[EXT_SIZE_BIT]; // see RL3
    assign ext_ok = !extword_i[EXT_ZERO_BIT] && (extword_i[EXT_RSV_LSB +: EXT_RSV_W] == '0);

    // ==================================================================
    // Opcode recognition
    logic hit_long; // Long-form multiply pattern
    logic hit_word; // Unsigned word multiply pattern
    logic hit_dneg; // Decimal negate pattern
    mdn_op_t op_kind; // Decoded operation

    assign hit_long = (opword_i[OPW_TOP_LSB +: 10] == LONG_MUL_PAT) && ext_ok; // see RL17
    assign hit_word = (opword_i[OPW_NIB_LSB +: 4] == WORD_MUL_PAT)
                      && (opword_i[OPW_SUB_LSB +: 3] == WORD_UNS_SUB); // see RL18
    assign hit_dneg = (opword_i[OPW_TOP_LSB +: 10] == DNEG_PAT); // see RL18
    // Patterns are disjoint, so the order here only fixes a default
    assign op_kind = hit_long ? OP_MUL_LONG : hit_word ? OP_MUL_WORD : hit_dneg ? OP_DNEG : OP_NONE;

    // ==================================================================
    // Operand legality
    logic ea_legal; // Addressing mode allowed for this kind
    logic ctrl_en_reg; // Software enable of the unit
    logic accept; // Operation will execute
    logic refuse; // Request present but not executed

    // Multiplies read any data mode; the negate must also write back
    assign ea_legal = (op_kind == OP_DNEG) ? ea_is_data_alt(ea_mode, ea_reg)
                                          : ea_is_data(ea_mode, ea_reg); // see RL1
    assign accept = op_valid_i && ctrl_en_reg && (op_kind != OP_NONE) && ea_legal;
    assign refuse = op_valid_i && !accept;

    // ==================================================================
    // Arithmetic engines
    mdn_dp_if dp ();

    mdn_mul u_mul (
        .dp(dp.mul_mp)
    );

    mdn_bcd u_bcd (
        .dp(dp.bcd_mp)
    );

    // Long form: full registers; word form: low halves only, unsigned
    assign dp.mul_a = (op_kind == OP_MUL_LONG) ? dst_i : {16'h0000, dst_i[15:0]}; // see RL2
    assign dp.mul_b = (op_kind == OP_MUL_LONG) ? src_i : {16'h0000, src_i[15:0]}; // see RL7
    assign dp.mul_signed = (op_kind == OP_MUL_LONG) && ext_signed; // see RL6
    // Only the low byte of the destination is negated
    assign dp.bcd_in = src_i[7:0]; // see RL12
    assign dp.bcd_x = ccr_i[CC_X]; // see RL13

    // ==================================================================
    // Multiply results and flags
    logic [31:0] prod_lo; // Low half of the product
    logic [31:0] prod_hi; // High half of the product
    logic wide_res; // 64-bit result returned
    logic mul_n; // Sign of the returned result
    logic mul_z; // Returned result is zero
    logic ovf_u; // Unsigned: discarded half nonzero
    logic ovf_s; // Signed: discarded half not a sign copy
    logic mul_v; // Overflow flag
    logic [CCR_W-1:0] mul_ccr; // Flags after a multiply

    assign prod_lo = dp.mul_prod[31:0]; // see RL8
    assign prod_hi = dp.mul_prod[63:32];
    assign wide_res = (op_kind == OP_MUL_LONG) && ext_wide; // see RL3
    // Word products never reach the high half, so one test serves both
    assign mul_n = wide_res ? prod_hi[31] : prod_lo[31]; // see RL9
    assign mul_z = wide_res ? (dp.mul_prod == '0) : (prod_lo == '0); // see RL9
    assign ovf_u = (prod_hi != '0); // see RL10
    assign ovf_s = (prod_hi != {32{prod_lo[31]}}); // see RL11
    // Overflow exists only for a long multiply kept to 32 bits
    assign mul_v = (op_kind == OP_MUL_LONG) && !ext_wide && (ext_signed ? ovf_s : ovf_u); // see RL10
    always_comb begin
        mul_ccr = ccr_i; // X passes through untouched, see RL9
        mul_ccr[CC_N] = mul_n;
        mul_ccr[CC_Z] = mul_z;
        mul_ccr[CC_V] = mul_v;
        mul_ccr[CC_C] = 1'b0; // see RL9
    end

    // ==================================================================
    // Decimal negate flags
    logic [CCR_W-1:0] bcd_ccr; // Flags after a decimal negate

    // N and V are undefined; holding them costs nothing and stays stable
    always_comb begin
        bcd_ccr = ccr_i;
        bcd_ccr[CC_C] = dp.bcd_borrow; // see RL14
        bcd_ccr[CC_X] = dp.bcd_borrow; // see RL14
        // Z only ever falls, so a chain of bytes keeps a running zero test
        if (dp.bcd_out != 8'h00) begin
            bcd_ccr[CC_Z] = 1'b0; // see RL15
        end
    end

    // ==================================================================
    // Write-back selection
    logic bcd_in_reg; // Negate target is a data register
    logic lo_wr_next;
    logic [2:0] lo_idx_next;
    logic [31:0] lo_data_next;
    logic hi_wr_next;
    logic mem_wr_next;
    logic [CCR_W-1:0] ccr_next;

    assign bcd_in_reg = (ea_mode == MODE_DREG);
    always_comb begin
        lo_wr_next = 1'b0;
        lo_idx_next = lo_idx_o;
        lo_data_next = lo_data_o;
        hi_wr_next = 1'b0;
        mem_wr_next = 1'b0;
        ccr_next = ccr_i; // Refused work leaves flags as they came
        if (accept) begin
            case (op_kind)
                OP_MUL_LONG: begin
                    lo_wr_next = 1'b1;
                    lo_idx_next = lo_num; // see RL2
                    lo_data_next = prod_lo; // see RL8
                    // With equal indices the core sees two writes; undefined, see RL5
                    hi_wr_next = ext_wide; // see RL4
                    ccr_next = mul_ccr;
                end
                OP_MUL_WORD: begin
                    lo_wr_next = 1'b1;
                    lo_idx_next = word_idx;
                    lo_data_next = prod_lo; // All 32 product bits, see RL7
                    ccr_next = mul_ccr;
                end
                OP_DNEG: begin
                    // Register targets keep their upper 24 bits
                    lo_wr_next = bcd_in_reg;
                    mem_wr_next = !bcd_in_reg;
                    lo_idx_next = ea_reg;
                    lo_data_next = {src_i[31:8], dp.bcd_out}; // see RL12
                    ccr_next = bcd_ccr;
                end
                default: begin
                    ccr_next = ccr_i;
                end
            endcase
        end
    end

    // ==================================================================
    // Result registers
    logic done_reg;
    logic refused_reg;
    logic lo_wr_reg;
    logic [2:0] lo_idx_reg;
    logic [31:0] lo_data_reg;
    logic hi_wr_reg;
    logic [2:0] hi_idx_reg;
    logic [31:0] hi_data_reg;
    logic mem_wr_reg;
    logic [CCR_W-1:0] ccr_reg;

    // Strobes last one cycle; low data and index hold until next accept, high ones until next 64-bit multiply
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_reg <= 1'b0;
            refused_reg <= 1'b0;
            lo_wr_reg <= 1'b0;
            lo_idx_reg <= 3'h0;
            lo_data_reg <= 32'h0000_0000;
            hi_wr_reg <= 1'b0;
            hi_idx_reg <= 3'h0;
            hi_data_reg <= 32'h0000_0000;
            mem_wr_reg <= 1'b0;
            ccr_reg <= '0;
        end else begin
            done_reg <= op_valid_i;
            refused_reg <= refuse;
            lo_wr_reg <= lo_wr_next;
            lo_idx_reg <= lo_idx_next;
            lo_data_reg <= lo_data_next;
            hi_wr_reg <= hi_wr_next;
            if (hi_wr_next) begin
                hi_idx_reg <= hi_num; // see RL4
                hi_data_reg <= prod_hi; // see RL4
            end
            mem_wr_reg <= mem_wr_next;
            if (op_valid_i) begin
                ccr_reg <= ccr_next;
            end
        end
    end

    assign done_o = done_reg;
    assign refused_o = refused_reg;
    assign lo_wr_o = lo_wr_reg;
    assign lo_idx_o = lo_idx_reg;
    assign lo_data_o = lo_data_reg;
    assign hi_wr_o = hi_wr_reg;
    assign hi_idx_o = hi_idx_reg;
    assign hi_data_o = hi_data_reg;
    assign mem_wr_o = mem_wr_reg;
    assign ccr_o = ccr_reg;

    // ==================================================================
    // Register port
    logic sel_ctrl; // Address hits the control word
    logic sel_stat; // Address hits the status word
    logic sel_count; // Address hits the counter
    logic ref_sticky_reg; // Some request was refused
    logic last_v_reg; // Overflow of last accepted operation, zero after a negate
    mdn_op_t last_op_reg; // Kind of last accepted operation
    logic [COUNT_W-1:0] count_reg; // Accepted operations, wraps
    logic [31:0] rd_mux; // Read data before the output flop
    logic [31:0] rdata_reg;

    assign sel_ctrl = (addr_i == ADDR_CTRL);
    assign sel_stat = (addr_i == ADDR_STAT);
    assign sel_count = (addr_i == ADDR_COUNT);

    // Control bit stops the unit; requests are then refused, not lost silently
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_en_reg <= CTRL_EN_RST;
        end else if (wr_i && sel_ctrl) begin
            ctrl_en_reg <= wdata_i[CTRL_EN_BIT];
        end
    end

    // Sticky refusal: a new refusal beats a clear in the same cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_sticky_reg <= 1'b0;
        end else if (refuse) begin
            ref_sticky_reg <= 1'b1;
        end else if (wr_i && sel_stat && wdata_i[STAT_REF_BIT]) begin
            ref_sticky_reg <= 1'b0;
        end
    end

    // Last-operation record for software inspection
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_v_reg <= 1'b0;
            last_op_reg <= OP_NONE;
        end else if (accept) begin
            last_v_reg <= (op_kind != OP_DNEG) && mul_v;
            last_op_reg <= op_kind;
        end
    end

    // Counter: an accept in the clearing cycle still counts as one
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_reg <= '0;
        end else if (wr_i && sel_count) begin
            count_reg <= COUNT_W'(accept);
        end else if (accept) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // Unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_ctrl) begin
            rd_mux[CTRL_EN_BIT] = ctrl_en_reg;
        end else if (sel_stat) begin
            rd_mux[STAT_REF_BIT] = ref_sticky_reg;
            rd_mux[STAT_V_BIT] = last_v_reg;
            rd_mux[STAT_OP_LSB +: 2] = last_op_reg;
        end else if (sel_count) begin
            rd_mux[COUNT_W-1:0] = count_reg;
        end
    end

    // Read data stands for the single cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_i) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign rdata_o = rdata_reg;
endmodule // mdn_unit

// ---- bench/mdn_unit_assertions.sv ----
// Port checker of the multiply and decimal negate unit
`timescale 1ns/1ps
module mdn_unit_assertions (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic op_valid_i,
    input wire logic [15:0] opword_i,
    input wire logic [mdn_pkg::CCR_W-1:0] ccr_i,
    input wire logic done_o,
    input wire logic refused_o,
    input wire logic lo_wr_o,
    input wire logic [31:0] lo_data_o,
    input wire logic hi_wr_o,
    input wire logic mem_wr_o,
    input wire logic [mdn_pkg::CCR_W-1:0] ccr_o,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o
);
    import mdn_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ==========
    // Accepted answers, split by kind of the request before
    sequence ok_s;
        done_o && !refused_o;
    endsequence
    sequence mul_s;
        ok_s ##0 ($past(opword_i[15:12]) == WORD_MUL_PAT || $past(opword_i[15:6]) == LONG_MUL_PAT);
    endsequence
    sequence neg_s;
        ok_s ##0 $past(opword_i[15:6]) == DNEG_PAT;
    endsequence
    // ==========
    // Answers
    answer_pulse_a: assert property (op_valid_i |=> done_o) else $error("no answer");
    done_cause_a: assert property (done_o |-> $past(op_valid_i)) else $error("stray answer");
    refuse_quiet_a: assert property (refused_o |-> !(lo_wr_o || hi_wr_o || mem_wr_o)
        && ccr_o == $past(ccr_i)) else $error("refusal wrote");
    hi_pair_a: assert property (hi_wr_o |-> lo_wr_o && done_o) else $error("lone high");
    mul_flags_a: assert property (mul_s |-> !ccr_o[CC_C] && ccr_o[CC_X] == $past(ccr_i[CC_X]))
        else $error("mul carry or extend");
    mul_zero_a: assert property (mul_s ##0 !hi_wr_o |-> ccr_o[CC_Z] == (lo_data_o == 32'h0)
        && ccr_o[CC_N] == lo_data_o[31]) else $error("mul zero or sign");
    neg_ext_a: assert property (neg_s |-> ccr_o[CC_X] == ccr_o[CC_C]) else $error("extend not carry");
    neg_zero_a: assert property (neg_s |-> ccr_o[CC_Z] == ($past(ccr_i[CC_Z]) && lo_data_o[7:0] == 8'h0))
        else $error("negate zero");
    read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0) else $error("read data idle");
endmodule // mdn_unit_assertions
bind mdn_unit mdn_unit_assertions mdn_unit_assertions_i (.*);

// ---- bench/mdn_rf_model.sv ----
// Data register file standing on the decoder side of the unit
`timescale 1ns/1ps
module mdn_rf_model (
    input wire logic clk_i,
    input wire logic lo_wr_i,
    input wire logic [2:0] lo_idx_i,
    input wire logic [31:0] lo_data_i,
    input wire logic hi_wr_i,
    input wire logic [2:0] hi_idx_i,
    input wire logic [31:0] hi_data_i,
    input wire logic [2:0] rd_idx_i,
    output logic [31:0] rd_data_o
);
    // Eight data registers, preset by the bench
    logic [31:0] rf [8];
    // Multiplicand read, combinational as in a real file
    assign rd_data_o = rf[rd_idx_i];
    // ==========
    // Write back; low lands last, so a clash keeps low
    always @(posedge clk_i) begin
        if (hi_wr_i) begin
            rf[hi_idx_i] <= hi_data_i;
        end
        if (lo_wr_i) begin
            rf[lo_idx_i] <= lo_data_i;
        end
    end
endmodule // mdn_rf_model

// ---- bench/testbench.sv ----
// Self-checking bench of the multiply and decimal negate unit
`timescale 1ns/1ps
module testbench;
    import mdn_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, op_valid_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [15:0] opword_i = 16'h0, extword_i = 16'h0;
    logic [31:0] src_i = 32'h0, wdata_i = 32'h0;
    logic [4:0] ccr_i = 5'h0;
    logic [3:0] addr_i = 4'h0;
    logic done_o, refused_o, lo_wr_o, hi_wr_o, mem_wr_o;
    logic [2:0] lo_idx_o, hi_idx_o, rd_idx;
    logic [31:0] dst_i, lo_data_o, hi_data_o, rdata_o;
    logic [4:0] ccr_o;
    int failures = 0, tests_run = 0;
    always #20 clk_i = ~clk_i;
    // Decoder picks the multiplicand register
    assign rd_idx = (opword_i[15:12] == WORD_MUL_PAT) ? opword_i[11:9] : extword_i[14:12];
    mdn_unit mdn_unit_i (.*);
    mdn_rf_model mdn_rf_model_i (.clk_i, .lo_wr_i(lo_wr_o), .lo_idx_i(lo_idx_o), .lo_data_i(lo_data_o),
        .hi_wr_i(hi_wr_o), .hi_idx_i(hi_idx_o), .hi_data_i(hi_data_o), .rd_idx_i(rd_idx), .rd_data_o(dst_i));
    // ==========
    // Compare, bus cycles, requests
    task automatic chk(input logic [79:0] s, e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stand one cycle after the strobe
    task automatic rd(input logic [3:0] a, logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, e);
    endtask
    task automatic op(input logic [15:0] w, e, logic [31:0] s, logic [4:0] c);
        @(posedge clk_i);
        op_valid_i <= 1'b1;
        opword_i <= w;
        extword_i <= e;
        src_i <= s;
        ccr_i <= c;
        @(posedge clk_i);
        op_valid_i <= 1'b0;
        #1;
        chk(done_o, 1'b1);
    endtask
    // Preset once the last write back has landed
    task automatic ld(input int k, input logic [31:0] d);
        @(posedge clk_i);
        #1;
        mdn_rf_model_i.rf[k] = d;
    endtask
    // Reference decimal negate: {borrow, two digits}
    function automatic logic [8:0] bneg(input logic [7:0] v, input logic x);
        int n;
        n = v[7:4] * 10 + v[3:0] + x;
        n = (100 - n) % 100;
        bneg = {(v != 8'h0) || x, 4'(n / 10), 4'(n % 10)};
    endfunction
    // ==========
    // Scenarios
    task automatic t_regs;
        rd(ADDR_CTRL, 32'h1);
        rd(ADDR_STAT, 32'h0);
        wr(4'hc, 32'hffff_ffff);
        rd(4'hc, 32'h0);
        $display("t_regs done");
    endtask
    task automatic t_long;
        logic [63:0] p;
        p = 64'h8000_0001 * 64'h3;
        ld(3, 32'h8000_0001);
        op(16'h4c00, 16'h3000, 32'h3, 5'h1f);
        chk({lo_wr_o, hi_wr_o, lo_idx_o, lo_data_o, ccr_o}, {2'b10, 3'h3, p[31:0], 5'h1a});
        ld(3, 32'h8000_0001);
        chk(mdn_rf_model_i.rf[3], 32'h8000_0001);
        op(16'h4c3c, 16'h3405, 32'h3, 5'h10); // High apart from low
        chk({hi_wr_o, hi_idx_o, hi_data_o, lo_data_o, ccr_o}, {1'b1, 3'h5, p, 5'h10});
        ld(3, 32'h4000_0000);
        op(16'h4c00, 16'h3800, 32'h2, 5'h00);
        chk({lo_data_o, ccr_o}, {32'h8000_0000, 5'h0a});
        $display("t_long done");
    endtask
    task automatic t_dneg;
        logic [7:0] v [5] = '{8'h00, 8'h00, 8'h01, 8'h99, 8'h45};
        logic [8:0] r;
        for (int i = 0; i < 5; i++) begin
            r = bneg(v[i], i[0]);
            op(i[0] ? 16'h4811 : 16'h4804, 16'h0, {24'ha5a5a5, v[i]}, {i[0], 1'b0, i < 3, 2'b0});
            chk({lo_wr_o, mem_wr_o, lo_data_o}, {~i[0], i[0], 24'ha5a5a5, r[7:0]});
            chk(ccr_o, {r[8], 1'b0, i < 3 && r[7:0] == 8'h0, 1'b0, r[8]});
        end
        $display("t_dneg done");
    endtask
    task automatic t_word;
        ld(2, 32'h1234_ffff);
        op(16'hc4f8, 16'h0, 32'hffff_ffff, 5'h1f); // Absolute short source
        chk({lo_wr_o, lo_idx_o, lo_data_o, ccr_o}, {1'b1, 3'h2, 32'hfffe_0001, 5'h18});
        $display("t_word done");
    endtask
    task automatic t_refuse;
        logic [15:0] w [5] = '{16'h4c09, 16'h4c3d, 16'hc4c9, 16'h483c, 16'h4c00};
        rd(ADDR_COUNT, 32'h9);
        for (int i = 0; i < 5; i++) begin
            op(w[i], i == 4 ? 16'hb000 : 16'h3000, 32'h5, 5'h0b);
            chk({refused_o, lo_wr_o, hi_wr_o, mem_wr_o, ccr_o}, {4'h8, 5'h0b});
        end
        rd(ADDR_STAT, 32'h21);
        wr(ADDR_STAT, 32'h1);
        rd(ADDR_STAT, 32'h20);
        wr(ADDR_CTRL, 32'h0);
        op(16'hc4c0, 16'h0, 32'h5, 5'h0);
        chk(refused_o, 1'b1);
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_COUNT, 32'h0);
        rd(ADDR_COUNT, 32'h0);
        $display("t_refuse done");
    endtask
    // ==========
    // Verdict, reached by the main run or the watchdog
    task automatic report_and_stop;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_long();
        t_dneg();
        t_word();
        t_refuse();
        report_and_stop();
    end
    // Run takes some 64 cycles; allow 1000
    initial begin
        #40000;
        failures++;
        report_and_stop();
    end
endmodule // testbench
